// ==== core/sbs_core.sv ====
// Command decode, burst addressing, data pipes and sleep control of the SRAM
// Function
// - Unstalled, load, store high, all selects active: read burst at external address.
// - Step high continues burst at next counter address, selects and store ignored.
// - Output drive high floats reads; drivers off by themselves during writes.
// - Selected load with store low and a lane low starts write; lanes masked.
// - Store low with all lanes high writes nothing and keeps bus floating.
// - Load with any chip select inactive deselects and floats outputs.
// - Deselect-continue only follows a deselect; outputs float throughout.
// - Edge gate high ignores edge, holds state; read keeps driving, write floats.
// - Two-bit burst counter returns to start after four accesses.
// - Burst counter advances on every continue cycle, including no-op ones.
// - Linear order steps low address bits modulo four.
// - Interleaved order XORs start with count.
// - Bypass low selects flow-through; high selects pipelined.
// - Sleep request low or open means active; high means standby.
// - Sleep entered five cycles after request; state kept, inputs off, outputs float.
// - Normal operation three cycles after request falls.
// - While sleeping the device is deselected and ignores other inputs.
// - All outputs float during power-up.
// - Pipelined read data appears after the edge following the address edge.
// - Flow-through pipes are one cycle shorter for reads and writes.
// - Each lane strobe enables one nine-bit lane; any combination allowed.
module sbs_core
   import sbs_pkg::*;
#(
   parameter int ADDR_W = sbs_pkg::ADDR_W_DEF,
   parameter int LANES  = sbs_pkg::LANES_DEF
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    edge_gate,
   input  wire logic                    load_or_step,
   input  wire logic                    store_select_n,
   input  wire logic [LANES-1:0]        lane_strobes_n,
   input  wire logic                    chip_select_lo_a,
   input  wire logic                    chip_select_hi,
   input  wire logic                    chip_select_lo_b,
   input  wire logic                    output_drive_n,
   input  wire logic                    sleep_request,
   input  wire logic                    bypass_out_reg_n,
   input  wire logic                    sequential_order_n,
   input  wire logic [ADDR_W-1:0]       addr,
   input  wire logic [LANES*9-1:0]      dq_in,
   output logic      [LANES*9-1:0]      dq_out,
   output logic                         dq_oe,
   output logic                         sleeping,
   output logic                         rd_valid,
   input  wire logic                    rd_ready
);
   import sbs_pkg::*;
   localparam int W = LANES * LANE_W;

   // ************************************************************
   // Input synchronisers for asynchronous pins
   // ************************************************************
   logic [2:0] async_s1_ff;
   logic [2:0] async_s2_ff;
   logic       oe_n_s;
   logic       zz_s;
   logic       ft_s;

   always_ff @(posedge sys_clk) begin
      async_s1_ff <= {output_drive_n, sleep_request, bypass_out_reg_n};
      async_s2_ff <= async_s1_ff;
   end
   assign oe_n_s = async_s2_ff[2];
   assign zz_s   = async_s2_ff[1];
   assign ft_s   = async_s2_ff[0];

   function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] start,
                                                    input logic [BURST_W-1:0] cnt,
                                                    input logic               ilv);
      burst_addr = ilv ? (start ^ cnt) : BURST_W'(start + cnt);
   endfunction : burst_addr

   // ************************************************************
   // Sleep control
   // ************************************************************
   sbs_slp_t   slp_ff;
   sbs_slp_t   nxt_slp;
   logic [1:0] slp_cnt_ff;
   logic [1:0] nxt_slp_cnt;
   logic       asleep;

   always_comb begin
      nxt_slp     = slp_ff;
      nxt_slp_cnt = slp_cnt_ff;
      case (slp_ff)
         SBS_AWAKE: begin
            if (zz_s) begin
               nxt_slp     = SBS_GOING;
               nxt_slp_cnt = 2'(SLEEP_IN_CYC - 1);
            end
         end
         SBS_GOING: begin
            if (!zz_s) begin
               nxt_slp = SBS_AWAKE;
            end else if (slp_cnt_ff == SLP_CNT_RST) begin
               nxt_slp = SBS_ASLEEP;
            end else begin
               nxt_slp_cnt = slp_cnt_ff - 2'h1;
            end
         end
         SBS_ASLEEP: begin
            if (!zz_s) begin
               nxt_slp     = SBS_WAKING;
               nxt_slp_cnt = 2'(SLEEP_OUT_CYC - 1);
            end
         end
         SBS_WAKING: begin
            if (zz_s) begin
               nxt_slp = SBS_ASLEEP;
            end else if (slp_cnt_ff == SLP_CNT_RST) begin
               nxt_slp = SBS_AWAKE;
            end else begin
               nxt_slp_cnt = slp_cnt_ff - 2'h1;
            end
         end
         default: nxt_slp = SBS_AWAKE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slp_ff     <= SBS_AWAKE;
         slp_cnt_ff <= SLP_CNT_RST;
      end else begin
         slp_ff     <= nxt_slp;
         slp_cnt_ff <= nxt_slp_cnt;
      end
   end
   // Waking cycles accept reads and deselects; host keeps to that
   assign asleep   = (slp_ff == SBS_ASLEEP);
   assign sleeping = asleep;

   // ************************************************************
   // Command decode and burst counter
   // ************************************************************
   logic              go;
   logic              sel;
   logic              any_lane;
   sbs_op_t           op_ff;
   sbs_op_t           nxt_op;
   logic [ADDR_W-1:0] base_ff;
   logic [ADDR_W-1:0] nxt_base;
   logic [1:0]        cnt_ff;
   logic [1:0]        nxt_cnt;
   logic [LANES-1:0]  lanes_ff;
   logic [LANES-1:0]  nxt_lanes;
   logic              cyc_rd;
   logic              cyc_wr;
   logic [ADDR_W-1:0] cyc_addr;

   assign go       = !edge_gate && !asleep;
   assign sel      = !chip_select_lo_a && chip_select_hi && !chip_select_lo_b;
   assign any_lane = !(&lane_strobes_n);

   always_comb begin
      nxt_op    = op_ff;
      nxt_base  = base_ff;
      nxt_cnt   = cnt_ff;
      nxt_lanes = ~lane_strobes_n;
      cyc_rd    = 1'b0;
      cyc_wr    = 1'b0;
      if (go) begin
         if (!load_or_step) begin
            nxt_base = addr;
            nxt_cnt  = BURST_RST;
            if (!sel) begin
               nxt_op = SBS_OP_IDLE;
            end else if (store_select_n) begin
               nxt_op = SBS_OP_READ;
               cyc_rd = 1'b1;
            end else begin
               nxt_op = SBS_OP_WRITE;
               cyc_wr = any_lane;
            end
         end else begin
            nxt_cnt = cnt_ff + 2'h1;
            cyc_rd  = (op_ff == SBS_OP_READ);
            cyc_wr  = (op_ff == SBS_OP_WRITE) && any_lane;
            // Idle stays idle: deselect continue, outputs float
         end
      end
   end

   assign cyc_addr = (!load_or_step) ? addr :
                     {base_ff[ADDR_W-1:BURST_W],
                      burst_addr(base_ff[BURST_W-1:0], nxt_cnt, sequential_order_n)};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         op_ff    <= SBS_OP_IDLE;
         base_ff  <= '0;
         cnt_ff   <= BURST_RST;
         lanes_ff <= '0;
      end else if (go) begin
         op_ff    <= nxt_op;
         base_ff  <= nxt_base;
         cnt_ff   <= nxt_cnt;
         lanes_ff <= nxt_lanes;
      end
   end

   // ************************************************************
   // Late write pipe: two stages pipelined, one flow-through
   // ************************************************************
   logic              wv1_ff, wv2_ff, nxt_wv1, nxt_wv2;
   logic [ADDR_W-1:0] wa1_ff, wa2_ff, nxt_wa1, nxt_wa2;
   logic [LANES-1:0]  wl1_ff, wl2_ff, nxt_wl1, nxt_wl2;
   logic              wr_now;
   logic [ADDR_W-1:0] wr_now_addr;
   logic [LANES-1:0]  wr_now_lane;
   logic              rd_pend_ff, nxt_rd_pend;

   always_comb begin
      nxt_wv1 = wv1_ff;
      nxt_wa1 = wa1_ff;
      nxt_wl1 = wl1_ff;
      nxt_wv2 = wv2_ff;
      nxt_wa2 = wa2_ff;
      nxt_wl2 = wl2_ff;
      if (go) begin
         nxt_wv1 = cyc_wr;
         nxt_wa1 = cyc_addr;
         nxt_wl1 = nxt_lanes & {LANES{cyc_wr}};
         nxt_wv2 = wv1_ff;
         nxt_wa2 = wa1_ff;
         nxt_wl2 = wl1_ff;
      end
   end

   // Data taken at the second edge flow-through, third edge pipelined
   assign wr_now      = go && (ft_s ? wv2_ff : wv1_ff);
   assign wr_now_addr = ft_s ? wa2_ff : wa1_ff;
   assign wr_now_lane = ft_s ? wl2_ff : wl1_ff;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wv1_ff <= 1'b0;
         wv2_ff <= 1'b0;
      end else begin
         wv1_ff <= nxt_wv1;
         wv2_ff <= nxt_wv2;
      end
      wa1_ff <= nxt_wa1;
      wa2_ff <= nxt_wa2;
      wl1_ff <= nxt_wl1;
      wl2_ff <= nxt_wl2;
   end

   // ************************************************************
   // Array and read data path
   // ************************************************************
   logic [W-1:0] arr_q;
   logic         skid_valid;
   logic [W-1:0] skid_data;

   sbs_mem #(
      .ADDR_W (ADDR_W),
      .WIDTH  (W),
      .LANES  (LANES)
   ) u_mem (
      .sys_clk (sys_clk),
      .wr_en   (wr_now),
      .wr_lane (wr_now_lane),
      .wr_addr (wr_now_addr),
      .wr_data (dq_in),
      .rd_en   (cyc_rd),
      .rd_addr (cyc_addr),
      .rd_data (arr_q)
   );

   assign nxt_rd_pend = cyc_rd;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_pend_ff <= 1'b0;
      end else if (go) begin
         rd_pend_ff <= nxt_rd_pend;
      end
   end

   // Read words also pass a two-entry buffer; words arriving while it is full are dropped
   sbs_skid #(
      .WIDTH (W)
   ) u_skid (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (rd_pend_ff && go),
      .in_ready  (),
      .in_data   (arr_q),
      .out_valid (skid_valid),
      .out_ready (rd_ready),
      .out_data  (skid_data)
   );
   assign rd_valid = skid_valid;

   // ************************************************************
   // Output register and drivers
   // ************************************************************
   logic [W-1:0] q_ff, nxt_q;
   logic         qv_ff, nxt_qv;
   logic         drv;

   always_comb begin
      nxt_q  = q_ff;
      nxt_qv = qv_ff;
      if (go) begin
         nxt_q  = arr_q;
         nxt_qv = rd_pend_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         qv_ff <= 1'b0;
         q_ff  <= '0;
      end else begin
         qv_ff <= nxt_qv;
         q_ff  <= nxt_q;
      end
   end

   // Stalls hold qv_ff/rd_pend_ff, so a read keeps driving; writes never drive
   // Bus drive never waits on the read buffer; the host bus cannot stall
   assign drv    = ft_s ? qv_ff : rd_pend_ff;
   assign dq_oe  = drv && !oe_n_s && !asleep && !rst;
   assign dq_out = ft_s ? q_ff : arr_q;
endmodule : sbs_core

// ==== include/sbs_pkg.sv ====
// Shared constants and types for the synchronous burst SRAM core
package sbs_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int LANES_DEF  = 4;
   localparam int LANE_W     = 9;
   localparam int ADDR_W_DEF = 10;
   localparam int BURST_W    = 2;

   // ************************************************************
   // Timing and reset values
   // ************************************************************
   localparam int SYS_CLK_HZ     = 10_000_000;
   localparam int SLEEP_IN_CYC   = 2;
   localparam int SLEEP_OUT_CYC  = 2;
   localparam logic [1:0] SLP_CNT_RST = 2'h0;
   localparam logic [1:0] BURST_RST   = 2'h0;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      SBS_OP_IDLE,
      SBS_OP_READ,
      SBS_OP_WRITE
   } sbs_op_t;

   typedef enum logic [1:0] {
      SBS_AWAKE,
      SBS_GOING,
      SBS_ASLEEP,
      SBS_WAKING
   } sbs_slp_t;
endpackage : sbs_pkg

// ==== core/sbs_mem.sv ====
// Storage array with byte-lane writes and registered read data
module sbs_mem #(
   parameter int ADDR_W = 10,
   parameter int WIDTH  = 36,
   parameter int LANES  = 4
) (
   input  wire logic              sys_clk,
   input  wire logic              wr_en,
   input  wire logic [LANES-1:0]  wr_lane,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]  wr_data,
   input  wire logic              rd_en,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [WIDTH-1:0]  rd_data
);
   localparam int LW = WIDTH / LANES;
   logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   // One process owns the array so lane writes never compete as drivers
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (wr_en && wr_lane[i]) begin
            mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : sbs_mem

// ==== core/sbs_skid.sv ====
// Two-entry buffer with valid and ready on both sides
module sbs_skid #(
   parameter int WIDTH = 36
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] ent_ff [0:1];
   logic [WIDTH-1:0] nxt_ent [0:1];
   logic [1:0]       cnt_ff;
   logic [1:0]       nxt_cnt;

   assign in_ready  = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data  = ent_ff[0];

   always_comb begin
      logic push;
      logic pop;
      push       = in_valid && in_ready;
      pop        = out_valid && out_ready;
      nxt_ent[0] = ent_ff[0];
      nxt_ent[1] = ent_ff[1];
      nxt_cnt    = cnt_ff;
      if (pop) begin
         nxt_ent[0] = ent_ff[1];
      end
      if (push) begin
         if (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop)) begin
            nxt_ent[0] = in_data;
         end else begin
            nxt_ent[1] = in_data;
         end
      end
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
      ent_ff[0] <= nxt_ent[0];
      ent_ff[1] <= nxt_ent[1];
   end
endmodule : sbs_skid

// ==== sim/sbs_monitor.sv ====
// Port assertions for the burst SRAM core
module sbs_monitor
   import sbs_pkg::*;
#(
   parameter int LANES = 4
) (
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               edge_gate,
   input wire logic               load_or_step,
   input wire logic               store_select_n,
   input wire logic               chip_select_lo_a,
   input wire logic               chip_select_hi,
   input wire logic               chip_select_lo_b,
   input wire logic               output_drive_n,
   input wire logic               sleep_request,
   input wire logic               bypass_out_reg_n,
   input wire logic [LANES*9-1:0] dq_out,
   input wire logic               dq_oe,
   input wire logic               sleeping
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sel;
   logic ld;
   assign sel = !chip_select_lo_a && chip_select_hi && !chip_select_lo_b;
   assign ld  = !edge_gate && !sleeping && !sleep_request && !load_or_step;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   a_write_float: assert property (ld && sel && !store_select_n && !bypass_out_reg_n
      |=> !dq_oe) else $error("bus driven after write");
   a_write_late: assert property (ld && sel && !store_select_n && bypass_out_reg_n
      ##1 !edge_gate |=> !dq_oe) else $error("bus driven after late write");
   a_desel_float: assert property (ld && !sel && !bypass_out_reg_n |=> !dq_oe)
      else $error("bus driven after deselect");
   a_desel_piped: assert property (ld && !sel && bypass_out_reg_n ##1 !edge_gate
      |=> !dq_oe) else $error("bus driven after piped deselect");
   a_read_drive: assert property ((!output_drive_n && !sleep_request && !sleeping)[*8]
      ##0 (ld && sel && store_select_n && !bypass_out_reg_n) |=> dq_oe)
      else $error("read not driven");
   a_read_piped: assert property ((!output_drive_n && !sleep_request && !sleeping)[*8]
      ##0 (ld && sel && store_select_n && bypass_out_reg_n) ##1 !edge_gate |=> dq_oe)
      else $error("piped read not driven");
   a_stall_hold: assert property (edge_gate && !sleeping && !sleep_request
      |=> $stable(dq_oe) && (!dq_oe || $stable(dq_out))) else $error("stall moved bus");
   a_sleep_early: assert property ($rose(sleep_request) && !sleeping |=> !sleeping)
      else $error("slept at once");
   a_sleep_enter: assert property (sleep_request[*6] |-> sleeping)
      else $error("no sleep");
   a_sleep_float: assert property (sleeping |-> !dq_oe)
      else $error("bus driven asleep");
   a_wake_late: assert property ($fell(sleep_request) && sleeping |=> sleeping)
      else $error("woke at once");
   a_wake_done: assert property ((!sleep_request)[*8] |-> !sleeping)
      else $error("still asleep");
endmodule : sbs_monitor

// ==== sim/sbs_host.sv ====
// Host-side reader of buffered read words
module sbs_host (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       stall,
   input  wire logic       rd_valid,
   output logic            rd_ready,
   output logic      [7:0] n_words
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rd_ready = 1'b0;
   // Stalls the read buffer on request and counts accepted words
   always @(posedge sys_clk) begin
      rd_ready <= !stall && !rst;
      if (rst)
         n_words <= 8'h00;
      else if (rd_valid && rd_ready)
         n_words <= n_words + 8'h01;
   end
endmodule : sbs_host

// ==== sim/tb_top.sv ====
// Directed testbench for the burst SRAM core
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sbs_pkg::*;
   logic        sys_clk = 1'b0, rst = 1'b1, edge_gate = 1'b0, load_or_step = 1'b0;
   logic        store_select_n = 1'b1, chip_select_lo_a = 1'b1, chip_select_hi = 1'b1;
   logic        chip_select_lo_b = 1'b0, output_drive_n = 1'b0, sleep_request = 1'b0;
   logic        bypass_out_reg_n = 1'b1, sequential_order_n = 1'b0, stall = 1'b0;
   logic        oe_w = 1'b0, zz_w = 1'b0, st_w = 1'b0, slp = 1'b0;
   logic        dq_oe, sleeping, rd_valid, rd_ready;
   logic [3:0]  lane_strobes_n = 4'hF;
   logic [9:0]  addr = 10'h000, base = 10'h000;
   logic [1:0]  cnt = 2'h0, op = 2'h0;
   logic [7:0]  n_words;
   logic [35:0] dq_in = 36'h0, dq_out;
   logic [35:0] mem [int];
   logic [35:0] ed [0:1];
   logic [35:0] dp [0:1] = '{36'h0, 36'h0};
   logic        eo [0:1] = '{1'b0, 1'b0};
   logic [3:0]  wl [0:5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'hF};
   int          errors = 0, n_tests = 0, lat = 1;
   sbs_core #(.ADDR_W(10), .LANES(4)) u_dut (
      .sys_clk            (sys_clk),
      .rst                (rst),
      .edge_gate          (edge_gate),
      .load_or_step       (load_or_step),
      .store_select_n     (store_select_n),
      .lane_strobes_n     (lane_strobes_n),
      .chip_select_lo_a   (chip_select_lo_a),
      .chip_select_hi     (chip_select_hi),
      .chip_select_lo_b   (chip_select_lo_b),
      .output_drive_n     (output_drive_n),
      .sleep_request      (sleep_request),
      .bypass_out_reg_n   (bypass_out_reg_n),
      .sequential_order_n (sequential_order_n),
      .addr               (addr),
      .dq_in              (dq_in),
      .dq_out             (dq_out),
      .dq_oe              (dq_oe),
      .sleeping           (sleeping),
      .rd_valid           (rd_valid),
      .rd_ready           (rd_ready)
   );
   sbs_host u_host (.sys_clk(sys_clk), .rst(rst), .stall(stall), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .n_words(n_words));
   always #50 sys_clk = ~sys_clk;
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // ************************************************************
   // One command per clock; the model tracks bus and array
   // ************************************************************
   task automatic cmd(input logic [2:0] k, input logic [9:0] a, input logic [3:0] ln,
                      input logic [35:0] d);
      logic [9:0] ca;
      @(negedge sys_clk);
      chk(dq_oe, eo[lat-1]);
      if (eo[lat-1])
         chk(dq_out, ed[lat-1]);
      output_drive_n = oe_w;
      sleep_request = zz_w;
      stall = st_w;
      edge_gate = (k == 3'h4);
      load_or_step = (k == 3'h3);
      store_select_n = !(k == 3'h2 || (k == 3'h0 && a[1:0] == 2'h3));
      lane_strobes_n = ln;
      chip_select_lo_a = (k == 3'h0 && a[1:0] == 2'h0);
      chip_select_hi = !(k == 3'h0 && a[1:0] == 2'h1);
      chip_select_lo_b = (k == 3'h0 && a[1:0] == 2'h2);
      addr = a;
      dq_in = dp[lat-1];
      if (k != 3'h4) begin
         eo[1] = eo[0];
         ed[1] = ed[0];
         dp[1] = dp[0];
         eo[0] = 1'b0;
         dp[0] = d;
         if (k == 3'h3 && !slp)
            cnt = cnt + 2'h1;
         else if (!slp) begin
            base = a;
            cnt = 2'h0;
            op = (k == 3'h0) ? 2'h0 : k[1:0];
         end
         ca = {base[9:2], sequential_order_n ? base[1:0] ^ cnt : base[1:0] + cnt};
         if (op == 2'h1 && !slp) begin
            eo[0] = !output_drive_n;
            ed[0] = mem[ca];
         end
         for (int i = 0; i < 4; i++)
            if (op == 2'h2 && !slp && !ln[i])
               mem[ca][i*9+:9] = d[i*9+:9];
      end
      @(posedge sys_clk);
   endtask : cmd
   task automatic idle(input int n);
      repeat (n) cmd(3'h0, 10'h000, 4'hF, 36'h0);
   endtask : idle
   task automatic phase(input logic byp, input logic seq);
      @(negedge sys_clk);
      rst = 1'b1;
      bypass_out_reg_n = byp;
      sequential_order_n = seq;
      lat = byp ? 2 : 1;
      repeat (3) @(negedge sys_clk);
      chk(dq_oe, 1'b0);
      chk(sleeping, 1'b0);
      chk(rd_valid, 1'b0);
      rst = 1'b0;
      idle(6);
      for (int i = 0; i < 6; i++)
         cmd(i ? 3'h3 : 3'h2, 10'h1FD, wl[i], {9{4'h1 + i[3:0]}});
      idle(2);
      cmd(3'h1, 10'h1FD, 4'hF, 36'h0);
      cmd(3'h3, 10'h000, 4'hF, 36'h0);
      cmd(3'h4, 10'h000, 4'hF, 36'h0);
      repeat (3) cmd(3'h3, 10'h000, 4'hF, 36'h0);
      for (int i = 3; i < 7; i++)
         cmd(3'h0, 10'(i % 4), 4'hF, 36'h0);
      cmd(3'h3, 10'h000, 4'hF, 36'h0);
      oe_w = 1'b1;
      idle(4);
      cmd(3'h1, 10'h1FD, 4'hF, 36'h0);
      cmd(3'h3, 10'h000, 4'hF, 36'h0);
      oe_w = 1'b0;
      st_w = 1'b1;
      idle(4);
      cmd(3'h1, 10'h1FC, 4'hF, 36'h0);
      repeat (3) cmd(3'h3, 10'h000, 4'hF, 36'h0);
      idle(3);
      st_w = 1'b0;
      idle(5);
      @(negedge sys_clk);
      chk(rd_valid, 1'b0);
      chk(n_words == 8'h00, 1'b0);
      zz_w = 1'b1;
      idle(7);
      @(negedge sys_clk);
      chk(sleeping, 1'b1);
      slp = 1'b1;
      cmd(3'h2, 10'h1FE, 4'h0, 36'h0);
      cmd(3'h1, 10'h1FD, 4'hF, 36'h0);
      idle(2);
      zz_w = 1'b0;
      idle(7);
      @(negedge sys_clk);
      chk(sleeping, 1'b0);
      slp = 1'b0;
      cmd(3'h1, 10'h1FE, 4'hF, 36'h0);
      idle(3);
   endtask : phase
   task automatic conclude();
      $display("comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude
   initial begin
      phase(1'b1, 1'b0);
      phase(1'b0, 1'b1);
      conclude();
   end
   initial begin
      repeat (2000) @(posedge sys_clk);
      errors++;
      conclude();
   end
endmodule : tb_top
bind sbs_core sbs_monitor #(.LANES(LANES)) u_mon (
   .sys_clk          (sys_clk),
   .rst              (rst),
   .edge_gate        (edge_gate),
   .load_or_step     (load_or_step),
   .store_select_n   (store_select_n),
   .chip_select_lo_a (chip_select_lo_a),
   .chip_select_hi   (chip_select_hi),
   .chip_select_lo_b (chip_select_lo_b),
   .output_drive_n   (output_drive_n),
   .sleep_request    (sleep_request),
   .bypass_out_reg_n (bypass_out_reg_n),
   .dq_out           (dq_out),
   .dq_oe            (dq_oe),
   .sleeping         (sleeping)
);
